// *** logic/alarm_eval_pkg.sv ***
// constants and types for the process alarm evaluator
`default_nettype none
package alarm_eval_pkg;

  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UPPER = 8'h04;
  localparam logic [7:0] OFS_LOWER = 8'h08;
  localparam logic [7:0] OFS_OUTER = 8'h0c;
  localparam logic [7:0] OFS_GOAL1 = 8'h10;
  localparam logic [7:0] OFS_GOAL2 = 8'h14;
  localparam logic [7:0] OFS_ADLY = 8'h18;
  localparam logic [7:0] OFS_RDLY = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ******************************
  // control field positions
  // ******************************
  localparam int KIND_LSB = 0;
  localparam int REF_LSB = 4;
  localparam int COLOUR_LSB = 6;
  localparam int OUTER_EN_BIT = 8;
  localparam int LATCH_LSB = 9;
  localparam int POLARITY_BIT = 11;
  localparam int PON_BIT = 12;
  localparam int GOAL2_DEV_BIT = 13;
  localparam int CTRL_W = 14;

  // ******************************
  // reset values
  // ******************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [15:0] ADLY_RST = 16'h000a;
  localparam logic [15:0] RDLY_RST = 16'h0000;
  localparam logic [15:0] PARAM_RST = 16'h0000;

  // ******************************
  // timing
  // ******************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_STEP_NS = 100_000_000;
  localparam int STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;

  // ******************************
  // encodings
  // ******************************
  typedef enum logic [2:0] {
    kind_off = 3'h0,
    kind_over = 3'h1,
    kind_under = 3'h2,
    kind_outside_window = 3'h3,
    kind_inside_window = 3'h4
  } kind_t;

  typedef enum logic [1:0] {
    reference_absolute = 2'h0,
    reference_dev_first_goal = 2'h1,
    reference_dev_second_goal = 2'h2,
    reference_profile_goal = 2'h3
  } ref_t;

  typedef enum logic [1:0] {
    colour_red = 2'h0,
    colour_amber = 2'h1,
    colour_green = 2'h2,
    colour_keep = 2'h3
  } colour_t;

  typedef enum logic [1:0] {
    latch_none = 2'h0,
    latch_panel = 2'h1,
    latch_both = 2'h2,
    latch_remote_clear = 2'h3
  } latch_t;

endpackage : alarm_eval_pkg
`default_nettype wire

// *** logic/process_alarm_evaluator.sv ***
// alarm evaluator for one process alarm channel with wishbone registers
//
// Overview of operation
// - kind off: channel raises no alarm and no display change; contact rests at its non-alarm level, high for closed polarity.
// - over kind: alarm while process value above upper trigger.
// - under kind: alarm while process value below lower trigger.
// - outside-window kind: alarm when value outside lower..upper window.
// - band kind: alarm when value inside lower..upper window.
// - absolute reference: parameters are the trigger levels directly.
// - deviation reference: trigger is parameter plus first or second goal.
// - profile reference: trigger is parameter plus instantaneous profile goal.
// - second goal is absolute, or a deviation following the first goal.
// - active alarm selects red, amber or green display; keep leaves it.
// - outer mode adds outer thresholds at an offset; off means none.
// - no latching: alarm drops as soon as condition goes.
// - panel latching: alarm held until a front-panel clear.
// - combined latching: held until panel or digital input clear.
// - remote latching: held until digital input clear; panel ignored.
// - contact polarity: open drives active, closed drives inactive on alarm.
// - option bit is read while control still holds its reset value, so alarm always starts inactive at power on.
// - assert delay in tenths of seconds, default one second.
// - release delay in tenths of seconds, default zero.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`default_nettype none
module process_alarm_evaluator
  import alarm_eval_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [15:0] pv_i,
  input wire logic pv_valid_i,
  input wire logic [15:0] profile_goal_i,
  input wire logic panel_clear_i,
  input wire logic remote_clear_i,
  output logic alarm_o,
  output logic outer_alarm_o,
  output logic contact_o,
  output logic colour_change_o,
  output logic [1:0] colour_o
);

  // ******************************
  // register file
  // ******************************
  logic [CTRL_W-1:0] ctrl_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] outer_r;
  logic [15:0] goal1_r;
  logic [15:0] goal2_r;
  logic [15:0] adly_r;
  logic [15:0] rdly_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic wr_stb;
  logic [31:0] status_w;

  kind_t kind;
  ref_t ref_sel;
  latch_t latch_sel;
  logic outer_en;
  logic polarity_nc;
  logic goal2_dev;

  assign kind = kind_t'(ctrl_r[KIND_LSB +: 3]);
  assign ref_sel = ref_t'(ctrl_r[REF_LSB +: 2]);
  assign latch_sel = latch_t'(ctrl_r[LATCH_LSB +: 2]);
  assign outer_en = ctrl_r[OUTER_EN_BIT];
  assign polarity_nc = ctrl_r[POLARITY_BIT];
  assign goal2_dev = ctrl_r[GOAL2_DEV_BIT];

  assign wr_stb = cyc_i && stb_i && we_i && !ack_r;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] v;
    v = old_v;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction : merge16

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end

  assign ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      upper_r <= PARAM_RST;
      lower_r <= PARAM_RST;
      outer_r <= PARAM_RST;
      goal1_r <= PARAM_RST;
      goal2_r <= PARAM_RST;
      adly_r <= ADLY_RST;
      rdly_r <= RDLY_RST;
    end else if (wr_stb) begin
      case (adr_i)
        OFS_CTRL: ctrl_r <= CTRL_W'(merge16(16'(ctrl_r), dat_i, sel_i));
        OFS_UPPER: upper_r <= merge16(upper_r, dat_i, sel_i);
        OFS_LOWER: lower_r <= merge16(lower_r, dat_i, sel_i);
        OFS_OUTER: outer_r <= merge16(outer_r, dat_i, sel_i);
        OFS_GOAL1: goal1_r <= merge16(goal1_r, dat_i, sel_i);
        OFS_GOAL2: goal2_r <= merge16(goal2_r, dat_i, sel_i);
        OFS_ADLY: adly_r <= merge16(adly_r, dat_i, sel_i);
        OFS_RDLY: rdly_r <= merge16(rdly_r, dat_i, sel_i);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_r) begin
      case (adr_i)
        OFS_CTRL: rdata_r <= 32'(ctrl_r);
        OFS_UPPER: rdata_r <= 32'(upper_r);
        OFS_LOWER: rdata_r <= 32'(lower_r);
        OFS_OUTER: rdata_r <= 32'(outer_r);
        OFS_GOAL1: rdata_r <= 32'(goal1_r);
        OFS_GOAL2: rdata_r <= 32'(goal2_r);
        OFS_ADLY: rdata_r <= 32'(adly_r);
        OFS_RDLY: rdata_r <= 32'(rdly_r);
        OFS_STATUS: rdata_r <= status_w;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign dat_o = rdata_r;

  // ******************************
  // trigger levels
  // ******************************
  logic signed [17:0] goal2_eff;
  logic signed [17:0] base;
  logic signed [17:0] trig_hi;
  logic signed [17:0] trig_lo;
  logic signed [17:0] outer_hi;
  logic signed [17:0] outer_lo;
  logic signed [17:0] pv_s;

  always_comb begin
    goal2_eff = goal2_dev ? 18'(signed'(goal1_r)) + 18'(signed'(goal2_r))
                          : 18'(signed'(goal2_r));
    case (ref_sel)
      reference_dev_first_goal: base = 18'(signed'(goal1_r));
      reference_dev_second_goal: base = goal2_eff;
      reference_profile_goal: base = 18'(signed'(profile_goal_i));
      default: base = 18'sh00000;
    endcase
    trig_hi = base + 18'(signed'(upper_r));
    trig_lo = base + 18'(signed'(lower_r));
    outer_hi = trig_hi + 18'(signed'(outer_r));
    outer_lo = trig_lo - 18'(signed'(outer_r));
    pv_s = 18'(signed'(pv_i));
  end

  // ******************************
  // channel enable, unused kind codes act as off
  // ******************************
  logic chan_off;

  assign chan_off = !(kind inside {kind_over, kind_under, kind_outside_window, kind_inside_window});

  // ******************************
  // comparison
  // ******************************
  logic cond;
  logic outer_cond;

  always_comb begin
    case (kind)
      kind_over: cond = pv_s > trig_hi;
      kind_under: cond = pv_s < trig_lo;
      kind_outside_window: cond = (pv_s > trig_hi) || (pv_s < trig_lo);
      kind_inside_window: cond = (pv_s >= trig_lo) && (pv_s <= trig_hi);
      default: cond = 1'b0;
    endcase
    outer_cond = outer_en && !chan_off && ((pv_s > outer_hi) || (pv_s < outer_lo));
  end

  // ******************************
  // delay step divider
  // ******************************
  logic [31:0] div_r;
  logic step;

  assign step = (div_r == 32'(STEP_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 32'h0000_0000;
    end else if (step) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
  end

  // ******************************
  // condition sample and timers
  // ******************************
  logic cond_r;
  logic [15:0] on_cnt_r;
  logic [15:0] off_cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_r <= 1'b0;
    end else if (pv_valid_i) begin
      cond_r <= cond;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_cnt_r <= 16'h0000;
      off_cnt_r <= 16'h0000;
    end else begin
      if (!cond_r) begin
        on_cnt_r <= 16'h0000;
      end else if (step && on_cnt_r != 16'hffff) begin
        on_cnt_r <= on_cnt_r + 16'h0001;
      end
      if (cond_r) begin
        off_cnt_r <= 16'h0000;
      end else if (step && off_cnt_r != 16'hffff) begin
        off_cnt_r <= off_cnt_r + 16'h0001;
      end
    end
  end

  // ******************************
  // alarm state, latch and clears
  // ******************************
  logic init_r;
  logic alarm_r;
  logic latched_r;
  logic clr_pend_r;
  logic outer_r2;
  logic clr_req;
  logic on_due;
  logic off_due;

  always_comb begin
    case (latch_sel)
      latch_panel: clr_req = panel_clear_i;
      latch_both: clr_req = panel_clear_i || remote_clear_i;
      latch_remote_clear: clr_req = remote_clear_i;
      default: clr_req = 1'b0;
    endcase
  end

  assign on_due = cond_r && cond && (on_cnt_r >= adly_r);
  assign off_due = !cond_r && !cond && (off_cnt_r >= rdly_r);

  // ******************************
  // power-on and alarm state
  // ******************************

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_r <= 1'b1;
    end else begin
      init_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_pend_r <= 1'b0;
    end else if (clr_req) begin
      clr_pend_r <= 1'b1;
    end else if (pv_valid_i) begin
      clr_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r <= 1'b0;
    end else if (init_r) begin
      alarm_r <= ctrl_r[PON_BIT];
    end else if (chan_off) begin
      alarm_r <= 1'b0;
    end else if (pv_valid_i) begin
      if (on_due) begin
        alarm_r <= 1'b1;
      end else if (off_due) begin
        alarm_r <= 1'b0;
      end
    end
  end

  // ******************************
  // latch
  // ******************************

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_r <= 1'b0;
    end else if (chan_off || latch_sel == latch_none) begin
      latched_r <= 1'b0;
    end else if (pv_valid_i) begin
      if (alarm_r || on_due) begin
        latched_r <= 1'b1;
      end else if (clr_pend_r || clr_req) begin
        latched_r <= 1'b0;
      end
    end
  end

  // ******************************
  // outer thresholds
  // ******************************

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      outer_r2 <= 1'b0;
    end else if (chan_off || !outer_en) begin
      outer_r2 <= 1'b0;
    end else if (pv_valid_i) begin
      outer_r2 <= outer_cond;
    end
  end

  // ******************************
  // outputs
  // ******************************
  logic alarm_eff;

  assign alarm_eff = alarm_r || latched_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_o <= 1'b0;
      outer_alarm_o <= 1'b0;
      contact_o <= 1'b0;
      colour_change_o <= 1'b0;
      colour_o <= colour_keep;
    end else begin
      alarm_o <= alarm_eff;
      outer_alarm_o <= outer_r2;
      contact_o <= polarity_nc ? !alarm_eff : alarm_eff;
      colour_change_o <= alarm_eff && (ctrl_r[COLOUR_LSB +: 2] != colour_keep);
      colour_o <= alarm_eff ? ctrl_r[COLOUR_LSB +: 2] : colour_keep;
    end
  end

  assign status_w = {8'h00, off_cnt_r[7:0], on_cnt_r[7:0],
                     3'h0, clr_pend_r, outer_r2, latched_r, alarm_r, cond_r};

endmodule : process_alarm_evaluator
`default_nettype wire

// *** test/alarm_eval_props.sv ***
// port checker for the process alarm evaluator
`default_nettype none
module alarm_eval_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic pv_valid_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic alarm_o,
  input wire logic contact_o,
  input wire logic colour_change_o,
  input wire logic [1:0] colour_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // assertions
  // ****
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ##1 ack_o ##1 !ack_o;
  endsequence
  a_req_acked: assert property (s_req |-> s_ack) else $error("request not acked once");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
  a_read_upper: assert property (ack_o |-> dat_o[31:24] == 8'h00) else $error("read data upper byte set");
  a_colour_idle: assert property (!alarm_o |-> colour_o == 2'h3 && !colour_change_o)
    else $error("colour change without alarm");
  a_colour_flag: assert property (colour_change_o |-> alarm_o && colour_o != 2'h3)
    else $error("colour flag wrong");
  a_contact_pol: assert property ($changed(contact_o ^ alarm_o) |-> ack_o || $past(ack_o) || $past(ack_o, 2))
    else $error("contact not following alarm");
  a_alarm_rise: assert property ($rose(alarm_o) |-> $past(pv_valid_i, 2))
    else $error("alarm rose off a sample");
endmodule : alarm_eval_props
`default_nettype wire

// *** test/process_source_model.sv ***
// process reading source, profile goal and clear keys
`default_nettype none
module process_source_model (
  input wire logic clk_i,
  output logic [15:0] pv_o,
  output logic pv_valid_o,
  output logic [15:0] profile_goal_o,
  output logic panel_clear_o,
  output logic remote_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // stimulus tasks
  // ****
  initial begin
    pv_o = 16'h0000;
    pv_valid_o = 1'b0;
    profile_goal_o = 16'h0000;
    panel_clear_o = 1'b0;
    remote_clear_o = 1'b0;
  end
  task automatic sample(input logic [15:0] v, input int gap);
    pv_o <= v;
    pv_valid_o <= 1'b1;
    @(posedge clk_i);
    pv_valid_o <= 1'b0;
    pv_o <= ~v;
    repeat (gap) @(posedge clk_i);
  endtask : sample
  task automatic set_goal(input logic [15:0] g);
    profile_goal_o <= g;
  endtask : set_goal
  task automatic clear(input logic remote);
    panel_clear_o <= !remote;
    remote_clear_o <= remote;
    @(posedge clk_i);
    panel_clear_o <= 1'b0;
    remote_clear_o <= 1'b0;
  endtask : clear
endmodule : process_source_model
`default_nettype wire

// *** test/process_alarm_evaluator_tb_top.sv ***
// self-checking bench for the process alarm evaluator
`default_nettype none
module process_alarm_evaluator_tb_top import alarm_eval_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [15:0] pv_i, profile_goal_i;
  logic pv_valid_i, panel_clear_i, remote_clear_i, ack_o, alarm_o, outer_alarm_o, contact_o, colour_change_o;
  logic [1:0] colour_o;
  logic [13:0] c;
  logic signed [15:0] v, up, lw, g1, g2, pg;
  logic [7:0] ra[5] = '{OFS_CTRL, OFS_UPPER, OFS_ADLY, OFS_RDLY, 8'h24};
  logic [15:0] rv[5] = '{16'(CTRL_RST), PARAM_RST, ADLY_RST, RDLY_RST, 16'h0000};
  logic [7:0] pa[5] = '{OFS_UPPER, OFS_LOWER, OFS_GOAL1, OFS_GOAL2, OFS_ADLY};
  logic [15:0] pd[5];
  int failures = 0, n_tests = 0;
  // ****
  // design, partner and clock
  // ****
  process_alarm_evaluator #(.STEP_CYC(4)) u_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pv_i, .pv_valid_i,
    .profile_goal_i, .panel_clear_i, .remote_clear_i, .alarm_o, .outer_alarm_o, .contact_o,
    .colour_change_o, .colour_o
  );
  process_source_model u_src (
    .clk_i, .pv_o(pv_i), .pv_valid_o(pv_valid_i), .profile_goal_o(profile_goal_i),
    .panel_clear_o(panel_clear_i), .remote_clear_o(remote_clear_i)
  );
  initial forever #5 clk_i = ~clk_i;
  // ****
  // tasks
  // ****
  task automatic final_report;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h3;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic run(input logic [13:0] cc, input logic signed [15:0] vv, input int n);
    wb(1'b1, OFS_CTRL, {18'h0, cc});
    repeat (n) u_src.sample(vv, $urandom_range(2, 1));
    repeat (3) @(posedge clk_i);
  endtask : run
  function automatic logic exp_alarm(input logic [13:0] cc, input logic signed [15:0] vv);
    logic signed [15:0] b;
    case (cc[5:4])
      2'h0: b = 16'sh0000;
      2'h1: b = g1;
      2'h2: b = cc[13] ? g1 + g2 : g2;
      default: b = pg;
    endcase
    case (cc[2:0])
      3'h1: return vv > b + up;
      3'h2: return vv < b + lw;
      3'h3: return vv > b + up || vv < b + lw;
      3'h4: return vv >= b + lw && vv <= b + up;
      default: return 1'b0;
    endcase
  endfunction : exp_alarm
  task automatic chk_out(input logic [13:0] cc, input logic e);
    chk("alarm", 16'(e), 16'(alarm_o));
    chk("contact", 16'(e ^ cc[11]), 16'(contact_o));
    chk("colour", 16'(e ? cc[7:6] : 2'h3), 16'(colour_o));
    chk("colour_flag", 16'(e && cc[7:6] != 2'h3), 16'(colour_change_o));
  endtask : chk_out
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(32'h1675));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      chk("reset", rv[i], q[15:0]);
    end
    chk("power_on", 16'h0000, 16'(alarm_o));
    wb(1'b1, 8'h24, $urandom);
    wb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 16'h0000, q[15:0]);
    up = 16'($urandom_range(150, 20));
    lw = -16'($urandom_range(150, 20));
    g1 = 16'($urandom_range(200));
    g2 = 16'($urandom_range(100)) - 16'sd50;
    pg = 16'($urandom_range(300)) - 16'sd150;
    u_src.set_goal(pg);
    pd = '{up, lw, g1, g2, 16'h0000};
    foreach (pa[i]) begin
      wb(1'b1, pa[i], {16'h0, pd[i]});
      wb(1'b0, pa[i], 32'h0);
      chk("param", pd[i], q[15:0]);
    end
    for (int i = 0; i < 40; i++) begin
      c = '0;
      c[2:0] = 3'($urandom_range(4));
      c[5:4] = i < 8 ? 2'h0 : 2'($urandom);
      c[7:6] = 2'($urandom);
      c[11] = 1'($urandom);
      c[13] = 1'($urandom);
      v = i < 8 ? (i % 2 == 1 ? up : lw) : 16'($urandom_range(600)) - 16'sd300;
      run(c, v, 3);
      chk_out(c, exp_alarm(c, v));
    end
    wb(1'b1, OFS_OUTER, 32'd50);
    run(14'h101, up + 16'sd60, 3);
    chk("outer", 16'h1, 16'(outer_alarm_o));
    run(14'h101, up + 16'sd40, 3);
    chk("outer", 16'h0, 16'(outer_alarm_o));
    run(14'h001, up + 16'sd60, 3);
    chk("outer", 16'h0, 16'(outer_alarm_o));
    run(14'h107, up + 16'sh3c, 3);
    chk("outer_spare_kind", 16'h0, 16'(outer_alarm_o));
    chk("alarm_spare_kind", 16'h0, 16'(alarm_o));
    for (int l = 1; l < 4; l++) begin
      c = 14'h001 | 14'(l << 9);
      run(c, up + 16'sd9, 3);
      run(c, up - 16'sd9, 3);
      chk("held", 16'h1, 16'(alarm_o));
      u_src.clear(1'b0);
      run(c, up - 16'sd9, 2);
      chk("panel", 16'(l == 3), 16'(alarm_o));
      u_src.clear(1'b1);
      run(c, up - 16'sd9, 2);
      chk("remote", 16'h0, 16'(alarm_o));
    end
    wb(1'b1, OFS_ADLY, 32'd2);
    wb(1'b1, OFS_RDLY, 32'd2);
    run(14'h001, up + 16'sd9, 2);
    chk("on_delay", 16'h0, 16'(alarm_o));
    run(14'h001, up + 16'sd9, 12);
    chk("on_delay", 16'h1, 16'(alarm_o));
    run(14'h001, up - 16'sd9, 2);
    chk("off_delay", 16'h1, 16'(alarm_o));
    run(14'h001, up - 16'sd9, 12);
    chk("off_delay", 16'h0, 16'(alarm_o));
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule : process_alarm_evaluator_tb_top
bind process_alarm_evaluator alarm_eval_props u_props (
  .clk_i, .rst_i, .cyc_i, .stb_i, .pv_valid_i, .dat_o, .ack_o, .alarm_o, .contact_o, .colour_change_o, .colour_o
);
`default_nettype wire
